// ===== verilog/trc_top.v
// The address map and the AXI4-Lite register port were left to the implementer.
`include "trc_regs.vh"

module trc_top #(
    parameter TICK_CYCLES = `TRC_TICK_CYCLES,
    parameter [`TRC_MS_W-1:0] HOLDOFF_MS = `TRC_HOLDOFF_MS
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rxValid,
    input  wire [7:0]  rxData,
    output reg         rxReady,
    input  wire        receiveKey,
    input  wire        carrierDetect,
    output reg         tapeValid,
    output reg  [7:0]  tapeData,
    output reg         flushReq,
    output reg         fileMarkReq,
    output reg         decodeValid,
    output reg  [7:0]  decodeData,
    output reg         transparentActive,
    output reg         remoteActive
);

    localparam ST_NORMAL = 2'h0;
    localparam ST_KEYB   = 2'h1;
    localparam ST_REMOTE = 2'h2;
    localparam ST_HOLD   = 2'h3;

    reg  [31:0]           ctrl_reg;
    reg  [3:0]            awAddr_reg;
    reg                   awHave_reg;
    reg  [31:0]           wData_reg;
    reg  [3:0]            wStrb_reg;
    reg                   wHave_reg;
    reg  [1:0]            state_reg;
    reg  [1:0]            state_next;
    reg  [31:0]           tickCnt_reg;
    reg                   tick_reg;
    reg  [2:0]            keySync_reg;
    reg  [2:0]            cdSync_reg;
    reg                   tapeValid_next;
    reg                   flush_next;
    reg                   mark_next;
    reg                   decode_next;
    reg                   timerClear;
    wire                  keyPress;
    wire                  carrierLost;
    wire                  rxTake;
    wire                  pageEn;
    wire                  exitOnCarrierLossSelect;
    wire [7:0]            pageChar;
    wire [7:0]            startChar;
    wire [`TRC_MS_W-1:0]  idleLimit;
    wire [`TRC_MS_W-1:0]  timerLimit;
    wire                  timerRun;
    wire                  timerExpired;
    wire [31:0]           statusWord;

    function [`TRC_MS_W-1:0] idleInterval;
        input [3:0] sw;
        begin
            case ({sw[0], sw[1], sw[2], sw[3]})
                4'h1:    idleInterval = `TRC_IDLE_100MS;
                4'h2:    idleInterval = `TRC_IDLE_475MS;
                4'h4:    idleInterval = `TRC_IDLE_1S;
                4'h9:    idleInterval = `TRC_IDLE_11S;
                4'hA:    idleInterval = `TRC_IDLE_52S;
                4'hC:    idleInterval = `TRC_IDLE_120S;
                // illegal switch mixes fall back to the range's shortest setting
                default: idleInterval = sw[0] ? `TRC_IDLE_11S : `TRC_IDLE_100MS;
            endcase
        end
    endfunction

    function [31:0] mergeBytes;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0]  strb;
        integer i;
        begin
            mergeBytes = oldWord;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
        end
    endfunction

    assign pageEn                  = ctrl_reg[`TRC_CTRL_PAGE_EN];
    assign exitOnCarrierLossSelect = ctrl_reg[`TRC_CTRL_EXIT_CD];
    assign pageChar                = ctrl_reg[`TRC_CTRL_PAGE_LSB +: 8];
    assign startChar               = ctrl_reg[`TRC_CTRL_START_LSB +: 8];
    assign idleLimit  = idleInterval(ctrl_reg[`TRC_CTRL_SW4:`TRC_CTRL_SW1]);
    assign keyPress    = keySync_reg[1] && !keySync_reg[2];
    assign carrierLost = !cdSync_reg[1] && cdSync_reg[2];
    assign rxTake      = rxValid && rxReady;
    assign timerRun    = (state_reg == ST_HOLD) ||
                         (state_reg == ST_REMOTE && !exitOnCarrierLossSelect);
    assign timerLimit  = (state_reg == ST_HOLD) ? HOLDOFF_MS : idleLimit;
    assign statusWord  = {28'h0000000, cdSync_reg[1], state_reg == ST_HOLD, remoteActive, transparentActive};

    // pins from outside: two flops, then a third for edge detection
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            keySync_reg <= 3'b000;
            cdSync_reg  <= 3'b000;
        end
        else
        begin
            keySync_reg <= {keySync_reg[1:0], receiveKey};
            cdSync_reg  <= {cdSync_reg[1:0], carrierDetect};
        end
    end

    // millisecond enable pulse
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tickCnt_reg <= 32'h00000000;
            tick_reg    <= 1'b0;
        end
        else
        begin
            tick_reg    <= tickCnt_reg >= TICK_CYCLES - 1;
            tickCnt_reg <= (tickCnt_reg >= TICK_CYCLES - 1) ? 32'h00000000 : tickCnt_reg + 32'h00000001;
        end
    end

    trc_timer #(.WIDTH (`TRC_MS_W)) u_timer (
        .clock   (clock),
        .rst_n   (rst_n),
        .tick    (tick_reg),
        .clear   (timerClear),
        .run     (timerRun),
        .limit   (timerLimit),
        .expired (timerExpired)
    );

    always @*
    begin
        state_next     = state_reg;
        tapeValid_next = 1'b0;
        flush_next     = 1'b0;
        mark_next      = 1'b0;
        decode_next    = 1'b0;
        timerClear     = 1'b0;
        case (state_reg)
            ST_NORMAL:
            begin
                if (rxTake && rxData != startChar)
                    decode_next = 1'b1;
                if (rxTake && rxData == startChar)
                begin
                    state_next = ST_REMOTE;
                    timerClear = 1'b1;
                end
                else if (keyPress)
                    state_next = ST_KEYB;
            end
            ST_KEYB:
            begin
                if (rxTake)
                    tapeValid_next = 1'b1;
                if (rxTake && pageEn && rxData == pageChar)
                begin
                    flush_next = 1'b1;
                    mark_next  = 1'b1;
                    timerClear = 1'b1;
                    state_next = ST_HOLD;
                end
                else if (keyPress)
                    state_next = ST_NORMAL;
            end
            ST_HOLD:
                if (timerExpired)
                    state_next = ST_KEYB;
            ST_REMOTE:
            begin
                if (rxTake)
                begin
                    tapeValid_next = 1'b1;
                    timerClear     = 1'b1;
                end
                if (exitOnCarrierLossSelect && carrierLost)
                    state_next = ST_NORMAL;
                else if (!exitOnCarrierLossSelect && timerExpired && !rxTake)
                begin
                    flush_next = 1'b1;
                    state_next = ST_NORMAL;
                end
            end
            default:
                state_next = ST_NORMAL;
        endcase
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg         <= ST_NORMAL;
            tapeValid         <= 1'b0;
            tapeData          <= 8'h00;
            flushReq          <= 1'b0;
            fileMarkReq       <= 1'b0;
            decodeValid       <= 1'b0;
            decodeData        <= 8'h00;
            transparentActive <= 1'b0;
            remoteActive      <= 1'b0;
            rxReady           <= 1'b0;
        end
        else
        begin
            state_reg         <= state_next;
            tapeValid         <= tapeValid_next;
            flushReq          <= flush_next;
            fileMarkReq       <= mark_next;
            decodeValid       <= decode_next;
            if (rxTake)
            begin
                tapeData   <= rxData;
                decodeData <= rxData;
            end
            transparentActive <= state_next != ST_NORMAL;
            remoteActive      <= state_next == ST_REMOTE;
            rxReady           <= state_next != ST_HOLD;
        end
    end

    // AXI4-Lite write: address and data taken in either order
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg      <= `TRC_CTRL_RESET;
            awAddr_reg    <= 4'h0;
            awHave_reg    <= 1'b0;
            wData_reg     <= 32'h00000000;
            wStrb_reg     <= 4'h0;
            wHave_reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TRC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awAddr_reg    <= s_axi_awaddr;
                awHave_reg    <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            else if (!awHave_reg && !s_axi_bvalid)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_reg    <= s_axi_wdata;
                wStrb_reg    <= s_axi_wstrb;
                wHave_reg    <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            else if (!wHave_reg && !s_axi_bvalid)
                s_axi_wready <= 1'b1;
            if (awHave_reg && wHave_reg && !s_axi_bvalid)
            begin
                awHave_reg   <= 1'b0;
                wHave_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ({awAddr_reg[3:2], 2'b00} == `TRC_CTRL_ADDR)
                    ctrl_reg <= mergeBytes(ctrl_reg, wData_reg, wStrb_reg);
                // status writes are answered but have no effect
                s_axi_bresp <= ({awAddr_reg[3:2], 2'b00} > `TRC_STAT_ADDR) ? `TRC_RESP_DECERR : `TRC_RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TRC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= ({s_axi_araddr[3:2], 2'b00} == `TRC_CTRL_ADDR) ? ctrl_reg :
                             ({s_axi_araddr[3:2], 2'b00} == `TRC_STAT_ADDR) ? statusWord : 32'h00000000;
            s_axi_rresp   <= ({s_axi_araddr[3:2], 2'b00} > `TRC_STAT_ADDR) ? `TRC_RESP_DECERR : `TRC_RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

endmodule

// ===== verilog/trc_regs.vh
`ifndef TRC_REGS_VH
`define TRC_REGS_VH

`define TRC_ADDR_W          4
`define TRC_CTRL_ADDR       4'h0
`define TRC_STAT_ADDR       4'h4

`define TRC_CTRL_PAGE_EN    0
`define TRC_CTRL_EXIT_CD    1
`define TRC_CTRL_SW1        2
`define TRC_CTRL_SW2        3
`define TRC_CTRL_SW3        4
`define TRC_CTRL_SW4        5
`define TRC_CTRL_PAGE_LSB   8
`define TRC_CTRL_START_LSB  16
`define TRC_CTRL_RESET      32'h001B0C20

`define TRC_STAT_ACTIVE     0
`define TRC_STAT_REMOTE     1
`define TRC_STAT_HOLD       2
`define TRC_STAT_CARRIER    3

`define TRC_RESP_OKAY       2'h0
`define TRC_RESP_DECERR     2'h3

`define TRC_CLOCK_MHZ       200
`define TRC_TICK_US         1000
`define TRC_TICK_CYCLES     (`TRC_CLOCK_MHZ * `TRC_TICK_US)

`define TRC_MS_W            17
`define TRC_HOLDOFF_MS      17'h001F4
`define TRC_IDLE_100MS      17'h00064
`define TRC_IDLE_475MS      17'h001DB
`define TRC_IDLE_1S         17'h003E8
`define TRC_IDLE_11S        17'h02AF8
`define TRC_IDLE_52S        17'h0CB20
`define TRC_IDLE_120S       17'h1D4C0

`endif

// ===== verilog/trc_timer.v
module trc_timer #(
    parameter WIDTH = 17
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             tick,
    input  wire             clear,
    input  wire             run,
    input  wire [WIDTH-1:0] limit,
    output reg              expired
);

    reg [WIDTH-1:0] count_reg;

    // counts millisecond ticks; one pulse when the limit is reached
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= {WIDTH{1'b0}};
            expired   <= 1'b0;
        end
        else
        begin
            expired <= 1'b0;
            if (clear || !run)
                count_reg <= {WIDTH{1'b0}};
            else if (tick)
            begin
                if (count_reg + {{(WIDTH-1){1'b0}}, 1'b1} >= limit)
                begin
                    expired   <= 1'b1;
                    count_reg <= {WIDTH{1'b0}};
                end
                else
                    count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ===== testbench/trc_top_properties.sv
module trc_top_properties #(
    parameter int          TICK_CYCLES = 20,
    parameter logic [16:0] HOLDOFF_MS  = 17'h001F4
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       rxValid,
    input wire logic [7:0] rxData,
    input wire logic       rxReady,
    input wire logic       tapeValid,
    input wire logic [7:0] tapeData,
    input wire logic       flushReq,
    input wire logic       fileMarkReq,
    input wire logic       decodeValid,
    input wire logic [7:0] decodeData,
    input wire logic       transparentActive,
    input wire logic       remoteActive
);
    localparam int HOLD_LO = (HOLDOFF_MS - 1) * TICK_CYCLES;
    localparam int HOLD_HI = HOLDOFF_MS * TICK_CYCLES + 3;
    logic [31:0] holdCnt_reg;
    logic        take;
    assign take = rxValid && rxReady;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // length of the refusal window that follows a page mark
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            holdCnt_reg <= 32'h00000000;
        else if (fileMarkReq)
            holdCnt_reg <= 32'h00000001;
        else if (rxReady)
            holdCnt_reg <= 32'h00000000;
        else if (holdCnt_reg != 32'h00000000)
            holdCnt_reg <= holdCnt_reg + 32'h00000001;
    end

    a_tape_follows_take: assert property (take && transparentActive |=>
        tapeValid && tapeData == $past(rxData)) else $error("char not passed to tape");
    a_normal_decodes: assert property (take && !transparentActive |=>
        (decodeValid && decodeData == $past(rxData)) || remoteActive) else $error("char not decoded");
    a_tape_decode_excl: assert property (!(tapeValid && decodeValid))
        else $error("char both decoded and taped");
    a_page_flush_mark: assert property (fileMarkReq |-> flushReq && tapeValid && !rxReady)
        else $error("page mark without flush");
    a_holdoff_length: assert property (rxReady && holdCnt_reg != 16'h0000 |->
        holdCnt_reg >= HOLD_LO && holdCnt_reg <= HOLD_HI) else $error("holdoff length wrong");
    a_page_resumes: assert property (rxReady && holdCnt_reg != 16'h0000 |->
        transparentActive && !remoteActive) else $error("not back in keyboard mode");
    a_timeout_leaves: assert property (flushReq && !fileMarkReq |-> !transparentActive)
        else $error("timeout flush without exit");
    a_remote_inside: assert property (remoteActive |-> transparentActive)
        else $error("remote outside transparent");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");

    c_page: cover property (fileMarkReq);
    c_timeout: cover property (flushReq && !fileMarkReq);
    c_remote_end: cover property ($fell(remoteActive));
    c_decode: cover property (decodeValid);
endmodule

bind trc_top trc_top_properties #(.TICK_CYCLES(TICK_CYCLES), .HOLDOFF_MS(HOLDOFF_MS)) chk_u (
    .clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rxValid, .rxData, .rxReady, .tapeValid, .tapeData,
    .flushReq, .fileMarkReq, .decodeValid, .decodeData, .transparentActive, .remoteActive);

// ===== testbench/trc_remote_sender.sv
module trc_remote_sender (
    input  wire logic       clock,
    input  wire logic       rxReady,
    output logic            rxValid,
    output logic [7:0]      rxData,
    output logic            carrierDetect
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rxValid = 1'b0;
        rxData = 8'h00;
        carrierDetect = 1'b1;
    end
    task automatic send(input logic [7:0] c);
        @(posedge clock);
        rxValid <= 1'b1;
        rxData <= c;
        do @(posedge clock); while (rxReady !== 1'b1);
        rxValid <= 1'b0;
        rxData <= ~c;
    endtask
    task automatic setCarrier(input logic v);
        @(posedge clock);
        carrierDetect <= v;
    endtask
endmodule

// ===== testbench/tb_transparent_receive_control.sv
`include "trc_regs.vh"

module tb_transparent_receive_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 2;
    localparam int H = 4;
    logic        clock, rst_n, receiveKey, rxValid, rxReady, carrierDetect, tapeValid, flushReq;
    logic        fileMarkReq, decodeValid, transparentActive, remoteActive;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [7:0]  rxData, tapeData, decodeData, lastTape, lastDecode;
    logic [7:0]  swSel[4] = '{8'h20, 8'h10, 8'h08, 8'h24};
    int          msSel[4] = '{100, 475, 1000, 11000};
    int          n_fail, cmp_count, cyc, nTape, nDecode, nFlush, nMark, n;

    trc_top #(.TICK_CYCLES(T), .HOLDOFF_MS(17'h00004)) dut_u (
        .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rxValid, .rxData, .rxReady, .receiveKey, .carrierDetect, .tapeValid, .tapeData, .flushReq,
        .fileMarkReq, .decodeValid, .decodeData, .transparentActive, .remoteActive);
    trc_remote_sender sender_u (.clock, .rxReady, .rxValid, .rxData, .carrierDetect);

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cyc++;
        if (tapeValid === 1'b1)
        begin
            nTape++;
            lastTape = tapeData;
        end
        if (decodeValid === 1'b1)
        begin
            nDecode++;
            lastDecode = decodeData;
        end
        if (flushReq === 1'b1) nFlush++;
        if (fileMarkReq === 1'b1) nMark++;
        if (cyc == 40000)
        begin
            n_fail++;
            $display("unexpected at %0t: run hung", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [3:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic pressKey;
        @(posedge clock);
        receiveKey <= 1'b1;
        repeat (4) @(posedge clock);
        receiveKey <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, receiveKey} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        rst_n = 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        axiRd(`TRC_CTRL_ADDR);
        chk(rd === `TRC_CTRL_RESET && resp === `TRC_RESP_OKAY, "control reset value");
        axiRd(4'h8);
        chk(resp === `TRC_RESP_DECERR, "unmapped read answer");
        axiWr(4'hC, 32'h0000_0000);
        chk(resp === `TRC_RESP_DECERR, "unmapped write answer");
        s_axi_wstrb <= 4'h2;
        axiWr(`TRC_CTRL_ADDR, 32'hFFFF_0DFF);
        s_axi_wstrb <= 4'hF;
        axiRd(`TRC_CTRL_ADDR);
        chk(rd === 32'h001B0D20 && resp === `TRC_RESP_OKAY, "byte lane write");
        axiWr(`TRC_CTRL_ADDR, `TRC_CTRL_RESET);
        chk(resp === `TRC_RESP_OKAY, "control restore");
        sender_u.send(8'h41);
        settle();
        chk(nDecode === 1 && lastDecode === 8'h41 && nTape === 0, "normal decode");
        pressKey();
        chk(transparentActive === 1'b1 && remoteActive === 1'b0, "key entry");
        sender_u.send(8'h1B);
        sender_u.send(8'h0C);
        settle();
        chk(nTape === 2 && lastTape === 8'h0C && nMark === 0 && remoteActive === 1'b0, "raw taping");
        axiWr(`TRC_CTRL_ADDR, 32'h001B0C21);
        sender_u.send(8'h0C);
        @(posedge clock);
        n = 1;
        while (rxReady !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        chk(n >= (H - 1) * T && n <= H * T + 3, "holdoff length");
        settle();
        chk(nMark === 1 && nFlush === 1 && lastTape === 8'h0C && transparentActive === 1'b1, "page");
        pressKey();
        chk(transparentActive === 1'b0, "key exit");
        sender_u.send(8'h0D);
        settle();
        chk(nDecode === 2 && lastDecode === 8'h0D, "decoding again");
        for (int i = 0; i < 4; i++)
        begin
            axiWr(`TRC_CTRL_ADDR, {24'h001B0C, swSel[i]});
            sender_u.send(8'h1B);
            settle();
            chk(remoteActive === 1'b1 && nDecode === 2, "remote entry");
            if (i == 0)
            begin
                pressKey();
                chk(remoteActive === 1'b1, "key ignored in remote");
                repeat (150) @(posedge clock);
            end
            sender_u.send(8'h33);
            n = 0;
            while (flushReq !== 1'b1 && n < 30000)
            begin
                @(posedge clock);
                n++;
            end
            chk(n >= (msSel[i] - 1) * T && n <= msSel[i] * T + 4, "idle interval");
            settle();
            chk(transparentActive === 1'b0 && lastTape === 8'h33, "timeout exit");
        end
        axiWr(`TRC_CTRL_ADDR, 32'h001B0C22);
        sender_u.send(8'h1B);
        repeat (600) @(posedge clock);
        axiRd(`TRC_STAT_ADDR);
        chk(rd[3:0] === 4'b1011, "carrier select keeps remote");
        sender_u.setCarrier(1'b0);
        repeat (8) @(posedge clock);
        #1;
        chk(transparentActive === 1'b0 && nFlush === 5, "carrier exit");
        sender_u.setCarrier(1'b1);
        end_of_test();
    end
endmodule
